// ### hw/baud_gen_defines.vh
// Register map, field positions, reset values and divider constants for the baud rate generator
`ifndef BAUD_GEN_DEFINES_VH
`define BAUD_GEN_DEFINES_VH

// Byte offsets on the Avalon-MM register bus
`define OFS_BAUD_CONTROL 5'h00
`define OFS_RECEIVE_STATUS_CONTROL 5'h04
`define OFS_BAUD_DIVISOR_LOW 5'h08
`define OFS_BAUD_DIVISOR_HIGH 5'h0c
`define OFS_TRANSMIT_STATUS_CONTROL 5'h10

// baud_control fields
`define BC_AUTOBAUD_OVF 7
`define BC_RECEIVER_IDLE 6
`define BC_CLOCK_POLARITY 4
`define BC_WIDE_DIVIDER 3
`define BC_WAKE_ENABLE 1
`define BC_AUTOBAUD_ENABLE 0
`define BC_WRITE_MASK 8'h1b

// receive_status_control fields
`define RC_SERIAL_ENABLE 7
`define RC_CONT_RECEIVE 4
`define RC_WRITE_MASK 8'hf8

// transmit_status_control fields
`define TC_CLOCK_SOURCE 7
`define TC_TRANSMIT_ENABLE 5
`define TC_SYNC_MODE 4
`define TC_HIGH_SPEED 2
`define TC_SHIFT_EMPTY 1
`define TC_WRITE_MASK 8'hfd

// Reset values
`define BAUD_CONTROL_RESET 8'h00
`define RECEIVE_CONTROL_RESET 8'h00
`define DIVISOR_RESET 8'h00
`define TRANSMIT_CONTROL_RESET 8'h00

// Prescaler last counts for the multipliers 64, 16 and 4
`define MULT_SEL_64 2'h0
`define MULT_SEL_16 2'h1
`define MULT_SEL_4 2'h2
`define PRESCALE_LAST_64 6'h3f
`define PRESCALE_LAST_16 6'h0f
`define PRESCALE_LAST_4 6'h03

`endif

// ### hw/rate_prescaler.v
// Prescaler that divides the system clock by 64, 16 or 4
`timescale 1ns/100ps
`include "baud_gen_defines.vh"

module rate_prescaler (
  input wire core_clk,
  input wire rst,
  input wire clear,
  input wire [1:0] multSel,
  output wire preTick
);

  reg [5:0] count;
  reg [5:0] lastCount;

  // Last count of the chosen multiplier
  always @* begin
    case (multSel)
      `MULT_SEL_64: lastCount = `PRESCALE_LAST_64;
      `MULT_SEL_16: lastCount = `PRESCALE_LAST_16;
      `MULT_SEL_4: lastCount = `PRESCALE_LAST_4;
      default: lastCount = `PRESCALE_LAST_4;
    endcase
  end

  // Compare with >= so a switch to a smaller multiplier never runs past the limit
  assign preTick = (count >= lastCount);

  // Free running divider, restarted by a divisor write
  always @(posedge core_clk) begin
    if (rst || clear || preTick) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

endmodule // rate_prescaler

// ### hw/baud_rate_timer.v
// Divisor counter that turns prescaler ticks into one baud tick per n+1 of them
`timescale 1ns/100ps

module baud_rate_timer (
  input wire core_clk,
  input wire rst,
  input wire clear,
  input wire preTick,
  input wire wideDivider,
  input wire [15:0] divisor,
  output wire timerTick
);

  reg [15:0] count;
  wire [15:0] limit;

  // In 8-bit mode only the low byte takes part in the count
  assign limit = wideDivider ? divisor : {8'h00, divisor[7:0]};
  assign timerTick = preTick && (count >= limit);

  // Counts prescaler ticks from 0 to n, then wraps
  always @(posedge core_clk) begin
    if (rst || clear) begin
      count <= 16'h0000;
    end else if (timerTick) begin
      count <= 16'h0000;
    end else if (preTick) begin
      count <= count + 16'h0001;
    end
  end

endmodule // baud_rate_timer

// ### hw/serial_baud_rate_generator.v
// Baud rate generator of the serial port unit with its Avalon-MM control registers
//
// Functional notes
// - One timer serves async and sync operation
// - Counts 8 bits, 16 bits when wide set
// - Free running; period set by divisor pair
// - Divisor n is the high:low byte pair
// - Async multiplier set by high-speed and wide
// - Sync mode ignores the high-speed select bit
// - Async, 8-bit, low speed: clock/(64(n+1))
// - Divisor write clears the timer at once
// - Receiver idle flag reads 1 when idle
// - High-speed bit set picks high-speed rate in async mode only
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "baud_gen_defines.vh"

module serial_baud_rate_generator (
  input wire core_clk,
  input wire rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire rxActive,
  output reg baudTick,
  output reg syncMode,
  output reg clockMaster,
  output reg clockPolarity,
  output reg serialEnable,
  output reg transmitEnable,
  output reg receiveEnable
);

  // Software visible state
  reg [7:0] baudControl;
  reg [7:0] receiveControl;
  reg [7:0] transmitControl;
  reg [7:0] divisorLow;
  reg [7:0] divisorHigh;
  reg receiverIdle;

  // Bus handshake
  wire busRequest;
  wire accessNow;
  wire writeNow;
  wire laneZero;
  reg [7:0] next_readByte;

  // Timer plumbing
  reg [1:0] multSel;
  wire divisorWrite;
  wire preTick;
  wire timerTick;
  wire wideDivider;
  wire highSpeed;
  wire syncSelect;

  // Field views of the control registers
  assign wideDivider = baudControl[`BC_WIDE_DIVIDER];
  assign highSpeed = transmitControl[`TC_HIGH_SPEED];
  assign syncSelect = transmitControl[`TC_SYNC_MODE];

  // ------------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------------

  // A request is held by the master until it sees waitrequest low
  assign busRequest = avs_read || avs_write;

  // Exactly one wait state: waitrequest drops in the cycle after the request
  assign accessNow = busRequest && !avs_waitrequest;
  assign writeNow = avs_write && accessNow;

  // All registers are eight bits wide, so only byte lane 0 carries data
  assign laneZero = avs_byteenable[0];

  // Waitrequest is high at rest and low for one cycle per access
  always @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (busRequest && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read multiplexer; unmapped offsets and unused bits read as zero
  always @* begin
    next_readByte = 8'h00;
    case (avs_address)
      `OFS_BAUD_CONTROL: begin
        next_readByte = baudControl & `BC_WRITE_MASK;
        next_readByte[`BC_RECEIVER_IDLE] = receiverIdle;
        next_readByte[`BC_AUTOBAUD_OVF] = 1'b0;
      end
      `OFS_RECEIVE_STATUS_CONTROL: begin
        next_readByte = receiveControl & `RC_WRITE_MASK;
      end
      `OFS_BAUD_DIVISOR_LOW: begin
        next_readByte = divisorLow;
      end
      `OFS_BAUD_DIVISOR_HIGH: begin
        next_readByte = divisorHigh;
      end
      `OFS_TRANSMIT_STATUS_CONTROL: begin
        next_readByte = transmitControl & `TC_WRITE_MASK;
        // No transmitter is attached here, so the shift register is always empty
        next_readByte[`TC_SHIFT_EMPTY] = 1'b1;
      end
      default: begin
        next_readByte = 8'h00;
      end
    endcase
  end

  // Read data are captured as waitrequest drops and held until the next read
  always @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, next_readByte};
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------

  // Writes land on the edge where the master sees waitrequest low
  always @(posedge core_clk) begin
    if (rst) begin
      baudControl <= `BAUD_CONTROL_RESET;
      receiveControl <= `RECEIVE_CONTROL_RESET;
      transmitControl <= `TRANSMIT_CONTROL_RESET;
    end else if (writeNow && laneZero) begin
      case (avs_address)
        `OFS_BAUD_CONTROL: begin
          baudControl <= avs_writedata[7:0] & `BC_WRITE_MASK;
        end
        `OFS_RECEIVE_STATUS_CONTROL: begin
          receiveControl <= avs_writedata[7:0] & `RC_WRITE_MASK;
        end
        `OFS_TRANSMIT_STATUS_CONTROL: begin
          transmitControl <= avs_writedata[7:0] & `TC_WRITE_MASK;
        end
        default: begin
          receiveControl <= receiveControl;
        end
      endcase
    end
  end

  // Divisor pair; each byte is written on its own offset
  always @(posedge core_clk) begin
    if (rst) begin
      divisorLow <= `DIVISOR_RESET;
      divisorHigh <= `DIVISOR_RESET;
    end else if (writeNow && laneZero) begin
      if (avs_address == `OFS_BAUD_DIVISOR_LOW) begin
        divisorLow <= avs_writedata[7:0];
      end
      if (avs_address == `OFS_BAUD_DIVISOR_HIGH) begin
        divisorHigh <= avs_writedata[7:0];
      end
    end
  end

  // Writing either byte of the pair restarts the whole chain, so the new
  // rate is seen on the next period rather than after a stale overflow
  assign divisorWrite = writeNow && laneZero &&
    ((avs_address == `OFS_BAUD_DIVISOR_LOW) || (avs_address == `OFS_BAUD_DIVISOR_HIGH));

  // ------------------------------------------------------------------
  // Receiver idle flag
  // ------------------------------------------------------------------

  // rxActive comes from receiver logic on this clock, so no synchroniser
  // is needed; the flag only follows the receiver and never latches
  always @(posedge core_clk) begin
    if (rst) begin
      receiverIdle <= 1'b1;
    end else begin
      receiverIdle <= !rxActive;
    end
  end

  // ------------------------------------------------------------------
  // Multiplier selection
  // ------------------------------------------------------------------

  // Sync mode always divides by 4 whatever the high-speed bit says;
  // async mode picks 64, 16 or 4 from the two select bits together
  always @* begin
    if (syncSelect) begin
      multSel = `MULT_SEL_4;
    end else begin
      case ({highSpeed, wideDivider})
        2'b00: multSel = `MULT_SEL_64;
        2'b01: multSel = `MULT_SEL_16;
        2'b10: multSel = `MULT_SEL_16;
        2'b11: multSel = `MULT_SEL_4;
        default: multSel = `MULT_SEL_64;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Timer chain
  // ------------------------------------------------------------------

  // One chain feeds both async and sync users of the port
  rate_prescaler prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .clear(divisorWrite),
    .multSel(multSel),
    .preTick(preTick)
  );

  // The count width follows the wide-divider bit
  baud_rate_timer timer (
    .core_clk(core_clk),
    .rst(rst),
    .clear(divisorWrite),
    .preTick(preTick),
    .wideDivider(wideDivider),
    .divisor({divisorHigh, divisorLow}),
    .timerTick(timerTick)
  );

  // Registered tick, one cycle wide, once per multiplier*(n+1) clocks.
  // A divisor write also kills a tick that would land in the same cycle.
  always @(posedge core_clk) begin
    if (rst) begin
      baudTick <= 1'b0;
    end else begin
      baudTick <= timerTick && !divisorWrite;
    end
  end

  // ------------------------------------------------------------------
  // Mode outputs for the transmitter and receiver
  // ------------------------------------------------------------------

  // Registered copies so every output leaves from a flip-flop; they lag
  // the register write by one cycle, which the serial logic tolerates
  always @(posedge core_clk) begin
    if (rst) begin
      syncMode <= 1'b0;
      clockMaster <= 1'b0;
      clockPolarity <= 1'b0;
      serialEnable <= 1'b0;
      transmitEnable <= 1'b0;
      receiveEnable <= 1'b0;
    end else begin
      syncMode <= syncSelect;
      clockMaster <= transmitControl[`TC_CLOCK_SOURCE];
      clockPolarity <= baudControl[`BC_CLOCK_POLARITY];
      serialEnable <= receiveControl[`RC_SERIAL_ENABLE];
      transmitEnable <= transmitControl[`TC_TRANSMIT_ENABLE];
      receiveEnable <= receiveControl[`RC_CONT_RECEIVE];
    end
  end

endmodule // serial_baud_rate_generator

// ### test/baud_gen_monitor.sv
// Port checker for the baud rate generator, bound to its top module
`timescale 1ns/100ps
`include "baud_gen_defines.vh"
module baud_gen_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rxActive,
  input wire logic baudTick,
  input wire logic syncMode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Accepted accesses: the edge where waitrequest is sampled low
  wire wrOk = avs_write && avs_byteenable[0] && !avs_waitrequest;
  wire rdOk = avs_read && !avs_waitrequest;
  wire unmapped = avs_address[1:0] != 2'h0 || avs_address > `OFS_TRANSMIT_STATUS_CONTROL;
  sequence sDivWr;
    wrOk && (avs_address == `OFS_BAUD_DIVISOR_LOW || avs_address == `OFS_BAUD_DIVISOR_HIGH);
  endsequence
  // A cleared timer needs at least four cycles before it can tick
  sequence sQuiet;
    !baudTick [*4];
  endsequence
  AST_WAIT_ONE:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
  AST_WAIT_PULSE:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  AST_RD_UPPER:
    assert property (rdOk |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_RD_UNMAPPED:
    assert property (rdOk && unmapped |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  AST_DIV_CLEAR:
    assert property (sDivWr |=> sQuiet) else $error("tick soon after divisor write");
  AST_TICK_GAP:
    assert property (baudTick |=> !baudTick [*3]) else $error("ticks too close");
  AST_IDLE_FLAG:
    assert property (rdOk && avs_address == `OFS_BAUD_CONTROL && $stable(rxActive) && $past(rxActive, 2) == rxActive
      && $past(rxActive, 3) == rxActive |-> avs_readdata[6] == !rxActive) else $error("idle flag wrong");
  AST_SYNC_COPY:
    assert property (wrOk && avs_address == `OFS_TRANSMIT_STATUS_CONTROL |=> ##1 syncMode == $past(avs_writedata[4], 2))
      else $error("sync mode not copied");
  AST_SHIFT_EMPTY:
    assert property (rdOk && avs_address == `OFS_TRANSMIT_STATUS_CONTROL |-> avs_readdata[1]) else $error("empty bit low");
endmodule // baud_gen_monitor
bind serial_baud_rate_generator baud_gen_monitor i_mon (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxActive(rxActive), .baudTick(baudTick),
  .syncMode(syncMode));

// ### test/serial_baud_rate_generator_tb.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/100ps
`include "baud_gen_defines.vh"
module serial_baud_rate_generator_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic rxActive = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, baudTick, syncMode, clockMaster, clockPolarity, serialEnable, transmitEnable, receiveEnable;
  wire [5:0] modes = {syncMode, clockMaster, clockPolarity, serialEnable, transmitEnable, receiveEnable};
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int c, p;
  serial_baud_rate_generator i_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rxActive(rxActive), .baudTick(baudTick), .syncMode(syncMode),
    .clockMaster(clockMaster), .clockPolarity(clockPolarity), .serialEnable(serialEnable),
    .transmitEnable(transmitEnable), .receiveEnable(receiveEnable));
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // Holds the request until waitrequest is sampled low; idles one edge so no signal is driven twice at once
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    if (n >= 100) chk(1'b0, "bus hang");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // Counts cycles until baudTick, sampling after the edge has settled
  task automatic ticks(input int c0, output int k);
    k = c0;
    #1;
    while (baudTick !== 1'b1 && k < 20000) begin
      @(posedge core_clk);
      #1;
      k++;
    end
  endtask
  function automatic int mult(input logic s, input logic w, input logic h);
    mult = (s || (w && h)) ? 4 : (w || h) ? 16 : 64;
  endfunction
  task t_reset;
    bus(0, `OFS_BAUD_CONTROL, 0, 4'hf);
    chk(q === 32'h40, "idle at reset");
    bus(0, `OFS_BAUD_DIVISOR_HIGH, 0, 4'hf);
    chk(q === 32'h0, "divisor reset");
    bus(0, `OFS_TRANSMIT_STATUS_CONTROL, 0, 4'hf);
    chk(q === 32'h2, "tx reset");
    ticks(0, c);
    @(posedge core_clk);
    ticks(1, p);
    chk(p == 64, "reset period");
    $display("t_reset done");
  endtask
  task t_bus;
    bus(1, `OFS_BAUD_CONTROL, 8'hff, 4'hf);
    bus(1, `OFS_RECEIVE_STATUS_CONTROL, 8'hff, 4'hf);
    bus(1, `OFS_TRANSMIT_STATUS_CONTROL, 8'hff, 4'hf);
    bus(1, `OFS_BAUD_DIVISOR_LOW, 8'h55, 4'he);
    bus(1, 5'h14, 8'hff, 4'hf);
    chk({syncMode, clockMaster, clockPolarity, serialEnable, transmitEnable, receiveEnable} === 6'h3f, "modes");
    bus(0, `OFS_BAUD_CONTROL, 0, 4'hf);
    chk(q === 32'h5b, "baud control bits");
    bus(0, `OFS_RECEIVE_STATUS_CONTROL, 0, 4'hf);
    chk(q === 32'hf8, "receive bits");
    bus(0, `OFS_TRANSMIT_STATUS_CONTROL, 0, 4'hf);
    chk(q === 32'hff, "transmit bits");
    bus(0, `OFS_BAUD_DIVISOR_LOW, 0, 4'hf);
    chk(q === 32'h0, "byte enable off");
    bus(0, 5'h14, 0, 4'hf);
    chk(q === 32'h0, "unmapped");
    bus(1, `OFS_BAUD_CONTROL, 0, 4'hf);
    bus(1, `OFS_RECEIVE_STATUS_CONTROL, 0, 4'hf);
    bus(1, `OFS_TRANSMIT_STATUS_CONTROL, 0, 4'hf);
    bus(0, `OFS_BAUD_CONTROL, 0, 4'hf);
    chk(q === 32'h40, "baud control cleared");
    chk(modes === 6'h0, "modes off");
    $display("t_bus done");
  endtask
  task t_idle;
    rxActive <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, `OFS_BAUD_CONTROL, 0, 4'hf);
    chk(q[6] === 1'b0, "busy flag");
    rxActive <= 1'b0;
    repeat (3) @(posedge core_clk);
    bus(0, `OFS_BAUD_CONTROL, 0, 4'hf);
    chk(q[6] === 1'b1, "idle flag");
    $display("t_idle done");
  endtask
  // Every sync, wide and high-speed setting; high byte only counts in 16-bit mode
  task t_modes;
    int m, n;
    bus(1, `OFS_BAUD_DIVISOR_HIGH, 8'h01, 4'hf);
    bus(0, `OFS_BAUD_DIVISOR_HIGH, 0, 4'hf);
    chk(q === 32'h1, "high byte");
    for (int i = 0; i < 8; i++) begin
      m = mult(i[2], i[1], i[0]);
      n = i[1] ? 259 : 3;
      bus(1, `OFS_BAUD_CONTROL, {4'h0, i[1], 3'h0}, 4'hf);
      bus(1, `OFS_TRANSMIT_STATUS_CONTROL, {3'h0, i[2], 1'b0, i[0], 2'h0}, 4'hf);
      bus(1, `OFS_BAUD_DIVISOR_LOW, 8'h02, 4'hf);
      ticks(1, c);
      chk(c == m * n, "first tick");
      @(posedge core_clk);
      ticks(1, p);
      chk(p == m * n, "period");
    end
    $display("t_modes done");
  endtask
  // A reset in mid-run must undo a non-default setup and restart the 64-cycle count
  task t_midreset;
    bus(1, `OFS_TRANSMIT_STATUS_CONTROL, 8'hb4, 4'hf);
    bus(1, `OFS_BAUD_DIVISOR_LOW, 8'h05, 4'hf);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    ticks(0, c);
    chk(c == 64, "first tick after reset");
    @(posedge core_clk);
    chk(modes === 6'h0, "modes after reset");
    bus(0, `OFS_TRANSMIT_STATUS_CONTROL, 0, 4'hf);
    chk(q === 32'h2, "tx after reset");
    bus(0, `OFS_BAUD_DIVISOR_LOW, 0, 4'hf);
    chk(q === 32'h0, "divisor after reset");
    $display("t_midreset done");
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard well above the roughly 15000 cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_bus();
    t_idle();
    t_modes();
    t_midreset();
    give_verdict();
  end
endmodule // serial_baud_rate_generator_tb
